// ===== hdl/mqk_consts.svh
`ifndef MQK_CONSTS_SVH
`define MQK_CONSTS_SVH

// clock and timing
`define MQK_CLK_HZ            250000000
`define MQK_CLK_PERIOD_NS     4
`define MQK_PULSES_PER_INCH   100
`define MQK_MAX_PULSE_HZ      1000
`define MQK_REPORT_RATE_HZ    35
// least spacing between report starts, rounded up to whole cycles
`define MQK_REPORT_GAP_CYC    ((`MQK_CLK_HZ + `MQK_REPORT_RATE_HZ - 1) / `MQK_REPORT_RATE_HZ)
`define MQK_GAP_W             23

// movement word
`define MQK_ACC_W             12
`define MQK_MAG_MAX           7'h7F
`define MQK_DIR_X_POS         2'h0
`define MQK_DIR_X_NEG         2'h1
`define MQK_DIR_Y_POS         2'h2
`define MQK_DIR_Y_NEG         2'h3

// scan codes
`define MQK_SC_ALT            8'h38
`define MQK_SC_INDEX          8'h7C
`define MQK_SC_MIDDLE         8'h7D
`define MQK_SC_RING           8'h7E
`define MQK_SC_BREAK          8'h80
`define MQK_SC_DIGIT0         8'h0B
`define MQK_SC_DIGIT_BASE     8'h01
`define MQK_SC_NONE           8'h00

// emulated keystroke sequence
`define MQK_SEQ_LAST          4'h9

// quadrature positions (gray decoded to binary)
`define MQK_POS_FIRST         2'h0
`define MQK_POS_LAST          2'h3
`define MQK_POS_ILLEGAL       2'h2

`endif

// ===== hdl/mqk_pkg.sv
package mqk_pkg;

  typedef struct packed {
    logic a;
    logic b;
  } mqk_quad_t;

  typedef struct packed {
    logic [1:0] dir;
    logic [6:0] mag;
  } mqk_word_t;

  typedef enum logic [1:0] {
    MQK_IDLE = 2'b00,
    MQK_BTN  = 2'b01,
    MQK_MOVE = 2'b10
  } mqk_state_t;

endpackage : mqk_pkg

// ===== hdl/mqk_encoder.sv
// Behaviour
// - one count per quadrature pulse
// - track pulse trains up to about 1kHz
// - direction from phase order of each pair
// - only relative displacements, no absolute position
// - at most 35 movement reports per second
// - word bits 0-6 hold magnitude
// - bits 8:7 give direction code
// - word sent as five emulated keystrokes
// - header is ALT plus index button
// - three octal digit keys, most significant first
// - ALT, index make/break, ALT break, digits
// - buttons send make/break codes 124-126 by finger
// - hand mode swaps switch one and three codes
// - ALT+button one sets right mode, reset default
// - ALT+button two sets left mode
// - buttons pressed under ALT are swallowed
// - release code is press code plus 128
`timescale 1ns/100ps
`include "mqk_consts.svh"

module mqk_encoder
  import mqk_pkg::*;
#(
  parameter int unsigned REPORT_GAP_CYC = `MQK_REPORT_GAP_CYC
) (
  input  wire logic       mclk_in,            // keyboard controller clock
  input  wire logic       rst_n_in,           // synchronous reset, active low
  input  wire logic       x_phase_a_in,       // x axis phase a, asynchronous
  input  wire logic       x_phase_b_in,       // x axis phase b, asynchronous
  input  wire logic       y_phase_a_in,       // y axis phase a, asynchronous
  input  wire logic       y_phase_b_in,       // y axis phase b, asynchronous
  input  wire logic       button_one_in,      // switch 1, high when pressed
  input  wire logic       button_two_in,      // switch 2, high when pressed
  input  wire logic       button_three_in,    // switch 3, high when pressed
  input  wire logic       alt_held_in,        // ALT key held, same clock
  input  wire logic       code_ready_in,      // scan code sink ready
  output logic            code_valid_out,     // scan code offered
  output logic [7:0]      code_out,           // scan code
  output logic            left_hand_mode_out  // current hand mode
);

  localparam logic [`MQK_GAP_W-1:0] GAP_RELOAD = `MQK_GAP_W'(REPORT_GAP_CYC - 1);

  // ---------------- input synchronisers
  logic [6:0] meta_reg;
  logic [6:0] meta_next;
  logic [6:0] sync_reg;
  logic [6:0] sync_next;

  always_comb begin
    meta_next = {button_three_in, button_two_in, button_one_in,
                 y_phase_b_in, y_phase_a_in, x_phase_b_in, x_phase_a_in};
    sync_next = meta_reg;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      meta_reg <= 7'h00;
      sync_reg <= 7'h00;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  mqk_quad_t  quad [2];
  logic [2:0] btn_now;

  assign quad[0] = '{a: sync_reg[0], b: sync_reg[1]};
  assign quad[1] = '{a: sync_reg[2], b: sync_reg[3]};
  assign btn_now = sync_reg[6:4];

  // ---------------- quadrature decode per axis
  // sampling at 250 MHz leaves huge margin over 1kHz pulse trains
  logic [1:0] pos_reg  [2];
  logic [1:0] pos_next [2];
  logic [1:0] pos_cur  [2];
  logic       cnt_up   [2];
  logic       cnt_dn   [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_axis
      always_comb begin
        pos_cur[g]  = {quad[g].a, quad[g].a ^ quad[g].b};
        pos_next[g] = pos_reg[g];
        cnt_up[g]   = 1'b0;
        cnt_dn[g]   = 1'b0;
        // a jump of two positions means both phases moved: direction unknown
        if ((pos_cur[g] - pos_reg[g]) != `MQK_POS_ILLEGAL) begin
          pos_next[g] = pos_cur[g];
        end
        // count once per full cycle, sign from phase order
        if (pos_reg[g] == `MQK_POS_LAST && pos_cur[g] == `MQK_POS_FIRST) begin
          cnt_up[g] = 1'b1;
        end
        if (pos_reg[g] == `MQK_POS_FIRST && pos_cur[g] == `MQK_POS_LAST) begin
          cnt_dn[g] = 1'b1;
        end
      end

      always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
          pos_reg[g] <= `MQK_POS_FIRST;
        end else begin
          pos_reg[g] <= pos_next[g];
        end
      end
    end
  endgenerate

  // ---------------- helper functions
  function automatic logic [7:0] finger_code(input logic [1:0] idx, input logic left);
    logic [7:0] c;
    c = `MQK_SC_MIDDLE;
    if (idx == 2'h0) begin
      c = left ? `MQK_SC_RING : `MQK_SC_INDEX;
    end else if (idx == 2'h2) begin
      c = left ? `MQK_SC_INDEX : `MQK_SC_RING;
    end
    return c;
  endfunction : finger_code

  function automatic logic [7:0] digit_code(input logic [2:0] d);
    logic [7:0] c;
    c = (d == 3'h0) ? `MQK_SC_DIGIT0 : (`MQK_SC_DIGIT_BASE + 8'(d));
    return c;
  endfunction : digit_code

  function automatic logic [7:0] seq_code(input logic [3:0] step, input mqk_word_t w);
    logic [8:0] bits;
    logic [7:0] c;
    bits = w;
    case (step)
      4'h0:    c = `MQK_SC_ALT;
      4'h1:    c = `MQK_SC_INDEX;
      4'h2:    c = `MQK_SC_INDEX | `MQK_SC_BREAK;
      4'h3:    c = `MQK_SC_ALT | `MQK_SC_BREAK;
      4'h4:    c = digit_code(bits[8:6]);
      4'h5:    c = digit_code(bits[8:6]) | `MQK_SC_BREAK;
      4'h6:    c = digit_code(bits[5:3]);
      4'h7:    c = digit_code(bits[5:3]) | `MQK_SC_BREAK;
      4'h8:    c = digit_code(bits[2:0]);
      4'h9:    c = digit_code(bits[2:0]) | `MQK_SC_BREAK;
      default: c = `MQK_SC_NONE;
    endcase
    return c;
  endfunction : seq_code

  // ---------------- sender state
  mqk_state_t                 state_reg;
  mqk_state_t                 state_next;
  logic signed [`MQK_ACC_W-1:0] acc_reg  [2];
  logic signed [`MQK_ACC_W-1:0] acc_next [2];
  logic [`MQK_GAP_W-1:0]      gap_reg;
  logic [`MQK_GAP_W-1:0]      gap_next;
  logic [3:0]                 step_reg;
  logic [3:0]                 step_next;
  mqk_word_t                  word_reg;
  mqk_word_t                  word_next;
  logic [7:0]                 code_reg;
  logic [7:0]                 code_next;
  logic                       turn_reg;
  logic                       turn_next;
  logic                       left_reg;
  logic                       left_next;
  logic [2:0]                 rep_reg;
  logic [2:0]                 rep_next;
  logic [2:0]                 supp_reg;
  logic [2:0]                 supp_next;
  logic [7:0]                 held_reg  [3];
  logic [7:0]                 held_next [3];

  always_comb begin
    logic                         done;
    logic                         axis;
    logic signed [`MQK_ACC_W-1:0] sel;
    logic        [`MQK_ACC_W-1:0] absval;
    logic        [6:0]            mag;
    done       = 1'b0;
    axis       = 1'b0;
    sel        = '0;
    absval     = '0;
    mag        = 7'h00;
    state_next = state_reg;
    gap_next   = (gap_reg != '0) ? gap_reg - 1'b1 : gap_reg;
    step_next  = step_reg;
    word_next  = word_reg;
    code_next  = code_reg;
    turn_next  = turn_reg;
    left_next  = left_reg;
    rep_next   = rep_reg;
    supp_next  = supp_reg;
    for (int i = 0; i < 3; i++) begin
      held_next[i] = held_reg[i];
    end
    // only the pending displacement is kept, never a position
    for (int i = 0; i < 2; i++) begin
      acc_next[i] = acc_reg[i] + (cnt_up[i] ? `MQK_ACC_W'(1) : `MQK_ACC_W'(0))
                               - (cnt_dn[i] ? `MQK_ACC_W'(1) : `MQK_ACC_W'(0));
    end

    unique case (state_reg)
      MQK_IDLE: begin
        for (int i = 0; i < 3; i++) begin
          if (!done && btn_now[i] != rep_reg[i]) begin
            done        = 1'b1;
            rep_next[i] = btn_now[i];
            if (btn_now[i]) begin
              if (alt_held_in) begin
                supp_next[i] = 1'b1;
                if (i == 0) begin
                  left_next = 1'b0;
                end
                if (i == 1) begin
                  left_next = 1'b1;
                end
              end else begin
                // keep the press code so a mode change cannot orphan the release
                held_next[i] = finger_code(2'(i), left_reg);
                code_next    = finger_code(2'(i), left_reg);
                state_next   = MQK_BTN;
              end
            end else if (supp_reg[i]) begin
              supp_next[i] = 1'b0;
            end else begin
              code_next  = held_reg[i] | `MQK_SC_BREAK;
              state_next = MQK_BTN;
            end
          end
        end
        if (!done && gap_reg == '0 && (acc_reg[0] != '0 || acc_reg[1] != '0)) begin
          // alternate axes so one busy axis cannot starve the other
          axis   = (acc_reg[0] == '0) || (acc_reg[1] != '0 && turn_reg);
          sel    = acc_reg[axis];
          absval = (sel < 0) ? `MQK_ACC_W'(-sel) : `MQK_ACC_W'(sel);
          mag    = (absval > `MQK_ACC_W'(`MQK_MAG_MAX)) ? `MQK_MAG_MAX : absval[6:0];
          word_next.mag = mag;
          if (!axis) begin
            word_next.dir = (sel < 0) ? `MQK_DIR_X_NEG : `MQK_DIR_X_POS;
          end else begin
            word_next.dir = (sel < 0) ? `MQK_DIR_Y_NEG : `MQK_DIR_Y_POS;
          end
          // the remainder stays pending for the next report
          if (sel < 0) begin
            acc_next[axis] = acc_next[axis] + `MQK_ACC_W'(mag);
          end else begin
            acc_next[axis] = acc_next[axis] - `MQK_ACC_W'(mag);
          end
          turn_next  = ~axis;
          gap_next   = GAP_RELOAD;
          step_next  = 4'h0;
          code_next  = `MQK_SC_ALT;
          state_next = MQK_MOVE;
        end
      end
      MQK_BTN: begin
        if (code_ready_in) begin
          state_next = MQK_IDLE;
        end
      end
      MQK_MOVE: begin
        if (code_ready_in) begin
          if (step_reg == `MQK_SEQ_LAST) begin
            state_next = MQK_IDLE;
          end else begin
            step_next = step_reg + 4'h1;
            code_next = seq_code(step_reg + 4'h1, word_reg);
          end
        end
      end
      default: begin
        state_next = MQK_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_reg <= MQK_IDLE;
      acc_reg   <= '{default: '0};
      gap_reg   <= '0;
      step_reg  <= 4'h0;
      word_reg  <= '0;
      code_reg  <= `MQK_SC_NONE;
      turn_reg  <= 1'b0;
      left_reg  <= 1'b0;
      rep_reg   <= 3'h0;
      supp_reg  <= 3'h0;
      held_reg  <= '{default: `MQK_SC_NONE};
    end else begin
      state_reg <= state_next;
      acc_reg   <= acc_next;
      gap_reg   <= gap_next;
      step_reg  <= step_next;
      word_reg  <= word_next;
      code_reg  <= code_next;
      turn_reg  <= turn_next;
      left_reg  <= left_next;
      rep_reg   <= rep_next;
      supp_reg  <= supp_next;
      held_reg  <= held_next;
    end
  end

  assign code_valid_out     = (state_reg != MQK_IDLE);
  assign code_out           = code_reg;
  assign left_hand_mode_out = left_reg;

endmodule : mqk_encoder

// ===== verification/mqk_encoder_properties.sv
`timescale 1ns/100ps
module mqk_encoder_properties
  import mqk_pkg::*;
#(
  parameter int unsigned REPORT_GAP_CYC = 200
) (
  input wire logic       mclk_in,            // clock
  input wire logic       rst_n_in,           // reset, active low
  input wire logic       alt_held_in,        // alt key held
  input wire logic       code_ready_in,      // sink ready
  input wire logic       code_valid_out,     // code offered
  input wire logic [7:0] code_out,           // scan code
  input wire logic       left_hand_mode_out  // hand mode
);
  logic        prev_valid_reg;
  logic        prev_valid_next;
  int unsigned since_start_reg;
  int unsigned since_start_next;
  logic        move_start;

  assign move_start = code_valid_out && !prev_valid_reg && code_out == 8'h38;

  // saturates so a long quiet spell never wraps into a false early start
  always_comb begin
    prev_valid_next  = rst_n_in && code_valid_out;
    since_start_next = since_start_reg + ((since_start_reg == 32'hFFFFFFFF) ? 0 : 1);
    if (!rst_n_in) since_start_next = 32'hFFFFFFFF;
    else if (move_start) since_start_next = 1;
  end

  always_ff @(posedge mclk_in) begin
    prev_valid_reg  <= prev_valid_next;
    since_start_reg <= since_start_next;
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_taken(logic [7:0] c);
    code_valid_out && code_ready_in && code_out == c;
  endsequence

  a_reset_quiet: assert property ($rose(rst_n_in) |-> !code_valid_out && code_out == 8'h00
    && !left_hand_mode_out) else $error("outputs not idle after reset");
  a_code_hold: assert property (code_valid_out && !code_ready_in |=> code_valid_out
    && $stable(code_out)) else $error("offered code changed while stalled");
  a_header_index: assert property (s_taken(8'h38) |=> code_valid_out && code_out == 8'h7C)
    else $error("alt make not followed by index make");
  a_header_close: assert property (s_taken(8'h38) ##1 s_taken(8'h7C) |=> code_valid_out
    && code_out == 8'hFC) else $error("index make not followed by index break");
  a_digit_break: assert property (code_valid_out && code_ready_in && code_out inside {[8'h01:8'h0B]}
    |=> code_valid_out && code_out == ($past(code_out) | 8'h80)) else $error("digit break wrong");
  a_button_single: assert property (code_valid_out && code_ready_in
    && code_out inside {8'h7D, 8'h7E, 8'hFD, 8'hFE} |=> !code_valid_out)
    else $error("button code not alone");
  a_mode_alt: assert property ((!alt_held_in) [*4] |=> $stable(left_hand_mode_out))
    else $error("hand mode changed without alt");
  a_alt_silent: assert property (alt_held_in && $past(alt_held_in, 4)
    |-> !($rose(code_valid_out) && code_out != 8'h38)) else $error("button code sent under alt");
  a_report_gap: assert property (move_start |-> since_start_reg >= REPORT_GAP_CYC)
    else $error("movement reports too close");
endmodule : mqk_encoder_properties

bind mqk_encoder mqk_encoder_properties #(.REPORT_GAP_CYC(REPORT_GAP_CYC)) u_props (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .alt_held_in(alt_held_in),
  .code_ready_in(code_ready_in), .code_valid_out(code_valid_out), .code_out(code_out),
  .left_hand_mode_out(left_hand_mode_out));

// ===== verification/mqk_mouse_model.sv
`timescale 1ns/100ps
module mqk_mouse_model
  import mqk_pkg::*;
(
  input  wire logic clk_in,  // bench clock, changes land just after its edge
  output mqk_quad_t x_out,   // x pair
  output mqk_quad_t y_out,   // y pair
  output logic [2:0] btn_out // buttons, high when pressed
);
  // forward walk of {a,b}; walking it backwards reverses the sign
  logic [1:0] gray [4] = '{2'b00, 2'b01, 2'b11, 2'b10};

  initial begin
    x_out = 2'b00;
    y_out = 2'b00;
    btn_out = 3'b000;
  end

  // each phase level is held 4 cycles so the synchroniser sees every step
  task automatic move(input logic axis, input logic neg, input int n);
    int idx;
    for (int k = 0; k < 4 * n; k++) begin
      repeat (4) @(posedge clk_in);
      idx = neg ? 3 - k % 4 : (k + 1) % 4;
      if (axis) y_out <= gray[idx];
      else x_out <= gray[idx];
    end
  endtask : move

  task automatic glitch();
    repeat (4) @(posedge clk_in);
    x_out <= 2'b11;
    repeat (4) @(posedge clk_in);
    x_out <= 2'b00;
  endtask : glitch

  task automatic press(input int idx, input logic val);
    @(posedge clk_in);
    btn_out[idx] <= val;
  endtask : press
endmodule : mqk_mouse_model

// ===== verification/mqk_encoder_tb.sv
`timescale 1ns/100ps
module mqk_encoder_tb;
  import mqk_pkg::*;
  localparam int GAP = 4000;
  logic        mclk_in;
  logic        rst_n_in;
  logic        alt_held_in;
  logic        code_ready_in = 1'b0;
  logic        code_valid_out;
  logic        left_hand_mode_out;
  logic [7:0]  code_out;
  logic [2:0]  btn;
  mqk_quad_t   x_q;
  mqk_quad_t   y_q;
  logic [31:0] seed = 32'h78BF;
  logic [7:0]  exp_q[$];
  int          errors;
  int          checks;
  int          cycles = 0;

  mqk_mouse_model mouse (.clk_in(mclk_in), .x_out(x_q), .y_out(y_q), .btn_out(btn));
  mqk_encoder #(.REPORT_GAP_CYC(GAP)) dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .x_phase_a_in(x_q.a), .x_phase_b_in(x_q.b),
    .y_phase_a_in(y_q.a), .y_phase_b_in(y_q.b), .button_one_in(btn[0]),
    .button_two_in(btn[1]), .button_three_in(btn[2]), .alt_held_in(alt_held_in),
    .code_ready_in(code_ready_in), .code_valid_out(code_valid_out), .code_out(code_out),
    .left_hand_mode_out(left_hand_mode_out));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xorshift

  function automatic logic [7:0] digit_code(input logic [2:0] d);
    return (d == 3'h0) ? 8'h0B : {5'h00, d} + 8'h01;
  endfunction : digit_code

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic cmp_code(input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error code_out expected %h seen %h", exp, got);
    end
  endtask : cmp_code

  task automatic cmp_mode(input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error left_hand_mode_out expected %b seen %b", exp, got);
    end
  endtask : cmp_mode

  task automatic settle(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : settle

  task automatic click(input int idx, input logic alt);
    alt_held_in <= alt;
    mouse.press(idx, 1'b1);
    settle(40);
    mouse.press(idx, 1'b0);
    settle(40);
    alt_held_in <= 1'b0;
    settle(8);
  endtask : click

  task automatic expect_move(input logic [1:0] dir, input logic [6:0] mag);
    mqk_word_t w;
    w = '{dir: dir, mag: mag};
    exp_q.push_back(8'h38);
    exp_q.push_back(8'h7C);
    exp_q.push_back(8'hFC);
    exp_q.push_back(8'hB8);
    for (int k = 2; k >= 0; k--) begin
      exp_q.push_back(digit_code(w[3*k +: 3]));
      exp_q.push_back(digit_code(w[3*k +: 3]) | 8'h80);
    end
  endtask : expect_move

  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  // the sink stalls about one cycle in four
  always @(posedge mclk_in) begin
    seed          <= xorshift(seed);
    code_ready_in <= seed[0] | seed[1];
    cycles        <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      $display("Error run expected done seen timeout");
      final_report();
    end
  end

  always @(posedge mclk_in) begin
    if (rst_n_in === 1'b1 && code_valid_out === 1'b1 && code_ready_in === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("Error code_out expected none seen %h", code_out);
      end else begin
        cmp_code(exp_q.pop_front(), code_out);
      end
    end
  end

  initial begin
    rst_n_in = 1'b0;
    alt_held_in = 1'b0;
    errors = 0;
    checks = 0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    settle(2);
    cmp_mode(1'b0, left_hand_mode_out);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(8'h7C + 8'(i));
      exp_q.push_back(8'hFC + 8'(i));
      click(i, 1'b0);
    end
    $display("Test right hand buttons done");
    click(1, 1'b1);
    cmp_mode(1'b1, left_hand_mode_out);
    click(2, 1'b1);
    cmp_mode(1'b1, left_hand_mode_out);
    for (int i = 0; i < 3; i += 2) begin
      exp_q.push_back(8'h7E - 8'(i));
      exp_q.push_back(8'hFE - 8'(i));
      click(i, 1'b0);
    end
    click(0, 1'b1);
    cmp_mode(1'b0, left_hand_mode_out);
    // a reset in mid-run must bring back right hand mode
    click(1, 1'b1);
    cmp_mode(1'b1, left_hand_mode_out);
    rst_n_in <= 1'b0;
    settle(3);
    rst_n_in <= 1'b1;
    settle(2);
    cmp_mode(1'b0, left_hand_mode_out);
    $display("Test hand modes done");
    for (int d = 0; d < 4; d++) begin
      expect_move(2'(d), 7'h01);
      mouse.move(d[1], d[0], 1);
      settle(GAP + 100);
    end
    mouse.glitch();
    settle(GAP);
    $display("Test directions done");
    expect_move(2'h0, 7'h01);
    expect_move(2'h3, 7'h7F);
    expect_move(2'h3, 7'h03);
    mouse.move(1'b0, 1'b0, 1);
    mouse.move(1'b1, 1'b1, 130);
    settle(3 * GAP);
    checks++;
    if (exp_q.size() != 0) begin
      errors++;
      $display("Error pending codes expected 0 seen %0d", exp_q.size());
    end
    $display("Test split report done");
    final_report();
  end
endmodule : mqk_encoder_tb
